// ### src/gphy_ctl_regs.svh
`ifndef GPHY_CTL_REGS_SVH
`define GPHY_CTL_REGS_SVH
// register offsets (byte addresses within the port window)
`define OFS_PARTNER_NP 12'h110
`define OFS_GIG_CTRL 12'h112
`define OFS_GIG_STAT 12'h114
`define OFS_IRQ_STAT 12'h116
`define OFS_IRQ_MASK 12'h118
// control fields
`define CTL_TEST_HI 15
`define CTL_TEST_LO 13
`define CTL_MAN_EN 12
`define CTL_MAN_VAL 11
`define CTL_PORT_TYPE 10
`define CTL_ADV_FD 9
`define CTL_ADV_HD 8
`define CTL_RESET 16'h0200
`define CTL_WMASK 16'hFF00
// partner next-page fields
`define NP_MORE 15
`define NP_ACK 14
`define NP_MSG 13
`define NP_ACK2 12
`define NP_TOGGLE 11
`define NP_FIELD_HI 10
// status fields
`define ST_FAULT 15
`define ST_RESOLVED 14
`define ST_LOCAL_OK 13
`define ST_REMOTE_OK 12
`define ST_LP_FD 11
`define ST_LP_HD 10
// interrupt bits
`define IRQ_FAULT 0
`define IRQ_PAGE 1
`define IRQ_CNT_FULL 2
`define IRQ_W 3
`define TEST_LANES 4
`define CNT_MAX 8'hFF
`define ZERO16 16'h0000
`endif

// ### src/gphy_ctl_pkg.sv
package gphy_ctl_pkg;
  // transmitter test mode codes
  typedef enum logic [2:0] {
    TM_NORMAL = 3'h0,
    TM_WAVEFORM = 3'h1,
    TM_JITTER_MASTER = 3'h2,
    TM_JITTER_SLAVE = 3'h3,
    TM_DISTORTION = 3'h4
  } test_mode_e;

  // negotiation inputs to the master/slave resolver
  typedef struct packed {
    logic manual_en;
    logic manual_master;
    logic prefer_master;
    logic adv_fd;
    logic adv_hd;
  } neg_cfg_s;

  // link partner next page word as received
  typedef struct packed {
    logic more;
    logic ack;
    logic msg;
    logic ack2;
    logic toggle;
    logic [10:0] field;
  } next_page_s;

  // link state from the pma
  typedef struct packed {
    logic fault;
    logic resolved_master;
    logic local_ok;
    logic remote_ok;
    logic lp_fd;
    logic lp_hd;
  } link_stat_s;
endpackage : gphy_ctl_pkg

// ### src/idle_err_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "gphy_ctl_regs.svh"
module idle_err_counter #(
  parameter int W = 8
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic symbol_i,
  input wire logic rx_error_i,
  input wire logic rx_idle_i,
  input wire logic send_n_i,
  input wire logic clear_i,
  output logic [W-1:0] count_o,
  output logic full_o
);
  // refuse widths outside what the status word can hold
  if (W < 1 || W > 16) begin : g_bad_width
    $error("idle_err_counter: width out of range");
  end

  logic hit;
  // counts errored idle symbols while the transmitter sends normal data
  assign hit = symbol_i & rx_error_i & rx_idle_i & send_n_i;
  assign full_o = &count_o;

  // saturating counter, clear on read; a hit during clear counts as one
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_o <= '0;
    end else if (ce_i) begin
      if (clear_i) begin
        count_o <= hit ? W'(1) : '0;
      end else if (hit && !full_o) begin
        count_o <= count_o + W'(1);
      end
    end
  end
endmodule : idle_err_counter
`default_nettype wire

// ### src/gphy_ctl.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "gphy_ctl_regs.svh"
module gphy_ctl #(
  parameter int ADDR_W = 12,
  parameter int CNT_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // receive side from the pcs
  input wire logic page_valid_i,
  input wire gphy_ctl_pkg::next_page_s page_i,
  input wire gphy_ctl_pkg::link_stat_s link_i,
  input wire logic symbol_i,
  input wire logic rx_error_i,
  input wire logic rx_idle_i,
  input wire logic send_n_i,
  // toward negotiation and transmitter
  output gphy_ctl_pkg::neg_cfg_s neg_cfg_o,
  output gphy_ctl_pkg::test_mode_e test_mode_o,
  output logic [`TEST_LANES-1:0] test_lane_en_o,
  output logic irq_o
);
  // refuse widths that the register map cannot serve
  if (ADDR_W < 12 || CNT_W != 8) begin : g_bad_params
    $error("gphy_ctl: unsupported parameter values");
  end

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic sel_np;
  logic sel_ctl;
  logic sel_st;
  logic sel_is;
  logic sel_im;
  // full-width compare keeps upper bits from aliasing
  assign sel_np = addr_i == ADDR_W'(`OFS_PARTNER_NP);
  assign sel_ctl = addr_i == ADDR_W'(`OFS_GIG_CTRL);
  assign sel_st = addr_i == ADDR_W'(`OFS_GIG_STAT);
  assign sel_is = addr_i == ADDR_W'(`OFS_IRQ_STAT);
  assign sel_im = addr_i == ADDR_W'(`OFS_IRQ_MASK);

  // ------------------------------------------------------------
  // partner next page capture
  // ------------------------------------------------------------
  gphy_ctl_pkg::next_page_s np;

  // latest received next page word, held until the next one
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      np <= '0;
    end else if (ce_i && page_valid_i) begin
      np <= page_i;
    end
  end

  logic [15:0] np_word;
  // toggle reads inverted: 1 means the previous value was zero
  always_comb begin
    np_word = `ZERO16;
    np_word[`NP_MORE] = np.more;
    np_word[`NP_ACK] = np.ack;
    np_word[`NP_MSG] = np.msg;
    np_word[`NP_ACK2] = np.ack2;
    np_word[`NP_TOGGLE] = ~np.toggle;
    np_word[`NP_FIELD_HI:0] = np.field;
  end

  // ------------------------------------------------------------
  // gigabit control
  // ------------------------------------------------------------
  logic [15:0] ctl;

  // only 15:8 are writable, 7:0 stay zero
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl <= `CTL_RESET;
    end else if (ce_i && wr_i && sel_ctl) begin
      ctl <= wdata_i & `CTL_WMASK;
    end
  end

  // reserved test codes fall back to normal operation
  always_comb begin
    unique case (ctl[`CTL_TEST_HI:`CTL_TEST_LO])
      3'h1: test_mode_o = gphy_ctl_pkg::TM_WAVEFORM;
      3'h2: test_mode_o = gphy_ctl_pkg::TM_JITTER_MASTER;
      3'h3: test_mode_o = gphy_ctl_pkg::TM_JITTER_SLAVE;
      3'h4: test_mode_o = gphy_ctl_pkg::TM_DISTORTION;
      default: test_mode_o = gphy_ctl_pkg::TM_NORMAL;
    endcase
  end

  // any test mode drives every pair, no partner required
  assign test_lane_en_o = (test_mode_o != gphy_ctl_pkg::TM_NORMAL) ?
                          {`TEST_LANES{1'b1}} : '0;

  // role bits gated by manual enable
  always_comb begin
    neg_cfg_o.manual_en = ctl[`CTL_MAN_EN];
    neg_cfg_o.manual_master = ctl[`CTL_MAN_EN] &
                              ctl[`CTL_MAN_VAL];
    neg_cfg_o.prefer_master = ~ctl[`CTL_MAN_EN] &
                              ctl[`CTL_PORT_TYPE];
    neg_cfg_o.adv_fd = ctl[`CTL_ADV_FD];
    neg_cfg_o.adv_hd = ctl[`CTL_ADV_HD];
  end

  // ------------------------------------------------------------
  // gigabit status
  // ------------------------------------------------------------
  logic rd_st;
  logic fault;
  assign rd_st = rd_i & sel_st;

  // latch high fault, cleared by a status read; new fault wins
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault <= 1'b0;
    end else if (ce_i) begin
      if (link_i.fault) begin
        fault <= 1'b1;
      end else if (rd_st) begin
        fault <= 1'b0;
      end
    end
  end

  logic [CNT_W-1:0] idle_cnt;
  logic cnt_full;

  idle_err_counter #(
    .W(CNT_W)
  ) u_idle_cnt (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .symbol_i(symbol_i),
    .rx_error_i(rx_error_i),
    .rx_idle_i(rx_idle_i),
    .send_n_i(send_n_i),
    .clear_i(rd_st),
    .count_o(idle_cnt),
    .full_o(cnt_full)
  );

  logic [15:0] st_word;
  // status assembly, 9:8 reserved zero
  always_comb begin
    st_word = `ZERO16;
    st_word[`ST_FAULT] = fault;
    st_word[`ST_RESOLVED] = link_i.resolved_master;
    st_word[`ST_LOCAL_OK] = link_i.local_ok;
    st_word[`ST_REMOTE_OK] = link_i.remote_ok;
    st_word[`ST_LP_FD] = link_i.lp_fd;
    st_word[`ST_LP_HD] = link_i.lp_hd;
    st_word[CNT_W-1:0] = idle_cnt;
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  logic [`IRQ_W-1:0] irq_stat;
  logic [`IRQ_W-1:0] irq_mask;
  logic [`IRQ_W-1:0] irq_ev;
  logic full_d;

  // edge of counter saturation
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      full_d <= 1'b0;
    end else if (ce_i) begin
      full_d <= cnt_full;
    end
  end

  always_comb begin
    irq_ev = '0;
    irq_ev[`IRQ_FAULT] = link_i.fault;
    irq_ev[`IRQ_PAGE] = page_valid_i;
    irq_ev[`IRQ_CNT_FULL] = cnt_full & ~full_d;
  end

  // sticky bits, write one to clear, a new event wins
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_stat <= '0;
    end else if (ce_i) begin
      irq_stat <= (irq_stat & ~((wr_i && sel_is) ?
                  wdata_i[`IRQ_W-1:0] : '0)) | irq_ev;
    end
  end

  // interrupt mask, 1 enables
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_mask <= '0;
    end else if (ce_i && wr_i && sel_im) begin
      irq_mask <= wdata_i[`IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [15:0] next_rdata;
  // unmapped addresses read zero
  always_comb begin
    next_rdata = `ZERO16;
    if (sel_np) begin
      next_rdata = np_word;
    end else if (sel_ctl) begin
      next_rdata = ctl;
    end else if (sel_st) begin
      next_rdata = st_word;
    end else if (sel_is) begin
      next_rdata[`IRQ_W-1:0] = irq_stat;
    end else if (sel_im) begin
      next_rdata[`IRQ_W-1:0] = irq_mask;
    end
  end

  // data valid only in the cycle after the read strobe
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= `ZERO16;
    end else if (ce_i) begin
      rdata_o <= rd_i ? next_rdata : `ZERO16;
    end
  end
endmodule : gphy_ctl
`default_nettype wire

// ### bench/gphy_ctl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module gphy_ctl_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic page_valid_i,
  input wire logic symbol_i,
  input wire logic rx_error_i,
  input wire gphy_ctl_pkg::next_page_s page_i,
  input wire gphy_ctl_pkg::link_stat_s link_i,
  input wire gphy_ctl_pkg::neg_cfg_s neg_cfg_o,
  input wire logic [2:0] test_mode_o,
  input wire logic [3:0] test_lane_en_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [15:0] wd_q;
  gphy_ctl_pkg::next_page_s pg_q;
  gphy_ctl_pkg::link_stat_s lk_q;
  // history of write data, captured page and link levels
  always_ff @(posedge sys_clk_i) begin
    wd_q <= wdata_i;
    lk_q <= link_i;
    if (ce_i && page_valid_i) begin
      pg_q <= page_i;
    end
  end
  // ------
  // named steps
  // ------
  sequence s_rd(a);
    ce_i && rd_i && addr_i == a;
  endsequence
  sequence s_wr_ctl;
    ce_i && wr_i && addr_i == 12'h112;
  endsequence
  sequence s_quiet;
    !link_i.fault && !(symbol_i && rx_error_i);
  endsequence
  lane_follow_a: assert property (
    test_lane_en_o == {4{test_mode_o != gphy_ctl_pkg::TM_NORMAL}})
    else $error("lane enables wrong");
  test_code_a: assert property (s_wr_ctl |=>
    test_mode_o == ((wd_q[15:13] > 3'h4) ? 3'h0 : wd_q[15:13]))
    else $error("test mode wrong");
  man_role_a: assert property (s_wr_ctl |=>
    neg_cfg_o[4:2] == {wd_q[12], wd_q[12] & wd_q[11], !wd_q[12] & wd_q[10]})
    else $error("role config wrong");
  adv_dup_a: assert property (s_wr_ctl |=>
    neg_cfg_o[1:0] == wd_q[9:8]) else $error("duplex advert wrong");
  np_word_a: assert property (ce_i && page_valid_i ##1 !page_valid_i
    ##1 s_rd(12'h110) ##0 !page_valid_i |=> rdata_o == {pg_q[15:12],
    !pg_q.toggle, pg_q.field}) else $error("next page word wrong");
  stat_bits_a: assert property (s_rd(12'h114) ##0 $stable(link_i)
    |=> rdata_o[14:8] == {lk_q[4:0], 2'h0}) else $error("status bits wrong");
  fault_latch_a: assert property (ce_i && link_i.fault ##1 !rd_i
    ##1 s_rd(12'h114) |=> rdata_o[15]) else $error("fault not latched");
  rd_clear_a: assert property (s_rd(12'h114) ##0 s_quiet ##1 s_quiet
    ##1 s_rd(12'h114) |=> rdata_o[15] == 1'h0 && rdata_o[7:0] == 8'h00)
    else $error("read did not clear");
  freeze_ce_a: assert property (!ce_i |=>
    $stable(rdata_o) && $stable(neg_cfg_o) && $stable(test_mode_o))
    else $error("state moved while clock enable low");
endmodule : gphy_ctl_chk
bind gphy_ctl gphy_ctl_chk #(.ADDR_W(ADDR_W)) u_gphy_ctl_chk (
  .sys_clk_i(sys_clk_i),
  .resetn_i(resetn_i),
  .ce_i(ce_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .page_valid_i(page_valid_i),
  .symbol_i(symbol_i),
  .rx_error_i(rx_error_i),
  .page_i(page_i),
  .link_i(link_i),
  .neg_cfg_o(neg_cfg_o),
  .test_mode_o(test_mode_o),
  .test_lane_en_o(test_lane_en_o)
);
`default_nettype wire

// ### bench/link_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
  input wire logic sys_clk_i,
  output logic page_valid_o,
  output gphy_ctl_pkg::next_page_s page_o,
  output gphy_ctl_pkg::link_stat_s link_o,
  output logic symbol_o,
  output logic rx_error_o,
  output logic rx_idle_o,
  output logic send_n_o
);
  // quiet line until a task drives it
  initial begin
    page_valid_o = 1'h0;
    page_o = 16'h0000;
    link_o = 6'h00;
    {symbol_o, rx_error_o, rx_idle_o, send_n_o} = 4'h0;
  end
  // one page word, then the word no longer holds
  task automatic send_page(input logic [15:0] w);
    @(posedge sys_clk_i);
    page_o <= w;
    page_valid_o <= 1'h1;
    @(posedge sys_clk_i);
    page_o <= ~w;
    page_valid_o <= 1'h0;
  endtask : send_page
  // link levels; fault high for as long as asked
  task automatic set_link(input logic [5:0] v);
    @(posedge sys_clk_i);
    link_o <= v;
  endtask : set_link
  // n error symbols while idles arrive, send_n as given
  task automatic send_errors(input int n, input logic g);
    @(posedge sys_clk_i);
    {symbol_o, rx_error_o, rx_idle_o, send_n_o} <= {3'h7, g};
    repeat (n) @(posedge sys_clk_i);
    {symbol_o, rx_error_o, rx_idle_o, send_n_o} <= 4'h0;
  endtask : send_errors
endmodule : link_partner_model
`default_nettype wire

// ### bench/gphy_ctl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module gphy_ctl_bench;
  logic sys_clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic ce_i = 1'h1;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic [11:0] addr_i = 12'h000;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] rdata_o;
  logic page_valid_i, symbol_i, rx_error_i, rx_idle_i, send_n_i, irq_o;
  logic [3:0] test_lane_en_o;
  gphy_ctl_pkg::next_page_s page_i;
  gphy_ctl_pkg::link_stat_s link_i;
  gphy_ctl_pkg::neg_cfg_s neg_cfg_o;
  gphy_ctl_pkg::test_mode_e test_mode_o;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  gphy_ctl u_gphy_ctl (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .page_valid_i(page_valid_i),
    .page_i(page_i),
    .link_i(link_i),
    .symbol_i(symbol_i),
    .rx_error_i(rx_error_i),
    .rx_idle_i(rx_idle_i),
    .send_n_i(send_n_i),
    .neg_cfg_o(neg_cfg_o),
    .test_mode_o(test_mode_o),
    .test_lane_en_o(test_lane_en_o),
    .irq_o(irq_o)
  );
  link_partner_model u_link_partner_model (.sys_clk_i,
    .page_valid_o(page_valid_i), .page_o(page_i), .link_o(link_i),
    .symbol_o(symbol_i), .rx_error_o(rx_error_i), .rx_idle_o(rx_idle_i),
    .send_n_o(send_n_i));
  // 125 MHz clock
  always #4 sys_clk_i = ~sys_clk_i;
  // hang guard
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      test_done;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge sys_clk_i);
    wr_i <= 1'h0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [15:0] m,
                    input logic [15:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge sys_clk_i);
    rd_i <= 1'h0;
    #1 chk(rdata_o & m, e);
  endtask : rd
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  // ------
  // tests
  // ------
  initial begin
    repeat (4) @(posedge sys_clk_i);
    resetn_i <= 1'h1;
    rd(12'h112, 16'hFFFF, 16'h0200);
    rd(12'h114, 16'hFFFF, 16'h0000);
    rd(12'h110, 16'hFFFF, 16'h0800);
    $display("reset test done");
    wr(12'h100, 16'h0140);
    rd(12'h100, 16'hFFFF, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      wr(12'h112, {i[2:0], 13'h1FFF});
      #1 chk({13'h0000, test_mode_o}, (i > 4) ? 16'h0000 : 16'(i));
      chk({12'h000, test_lane_en_o}, (i inside {[1:4]}) ? 16'h000F : 16'h0000);
      rd(12'h112, 16'h1FFF, 16'h1F00);
    end
    chk({11'h000, neg_cfg_o}, 16'h001B);
    wr(12'h112, 16'h0F00);
    #1 chk({11'h000, neg_cfg_o}, 16'h0007);
    wr(12'h112, 16'h1400);
    #1 chk({11'h000, neg_cfg_o}, 16'h0010);
    // a write while the clock enable is low must leave control as it was
    @(posedge sys_clk_i);
    ce_i <= 1'h0;
    wr(12'h112, 16'hE300);
    ce_i <= 1'h1;
    rd(12'h112, 16'hFFFF, 16'h1400);
    $display("control test done");
    u_link_partner_model.send_page(16'hA5A5);
    rd(12'h110, 16'hFFFF, 16'hADA5);
    u_link_partner_model.send_page(16'h5A5A);
    rd(12'h110, 16'hFFFF, 16'h525A);
    wr(12'h118, 16'h0002);
    #1 chk({15'h0000, irq_o}, 16'h0001);
    wr(12'h116, 16'h0002);
    #1 chk({15'h0000, irq_o}, 16'h0000);
    $display("page test done");
    u_link_partner_model.set_link(6'h3F);
    u_link_partner_model.set_link(6'h1F);
    rd(12'h114, 16'hFF00, 16'hFC00);
    rd(12'h114, 16'hFF00, 16'h7C00);
    u_link_partner_model.set_link(6'h0A);
    rd(12'h114, 16'hFF00, 16'h2800);
    chk({15'h0000, irq_o}, 16'h0000);
    $display("status test done");
    u_link_partner_model.send_errors(3, 1'h0);
    u_link_partner_model.send_errors(5, 1'h1);
    rd(12'h114, 16'h00FF, 16'h0005);
    rd(12'h114, 16'h00FF, 16'h0000);
    u_link_partner_model.send_errors(300, 1'h1);
    rd(12'h114, 16'h00FF, 16'h00FF);
    rd(12'h116, 16'h0007, 16'h0005);
    wr(12'h116, 16'hFFFF);
    rd(12'h116, 16'h0007, 16'h0000);
    $display("counter test done");
    test_done;
  end
endmodule : gphy_ctl_bench
`default_nettype wire
